// file: verilog/dq_train_regs.vh
// constants for the dq training fifo: offsets, fields, codes, timing
`ifndef DQ_TRAIN_REGS_VH
`define DQ_TRAIN_REGS_VH

// ==========================================================
// register offsets (byte addresses)
`define REG_CTRL        8'h00
`define REG_CAL         8'h04
`define REG_STAT        8'h08

// ==========================================================
// ctrl fields and reset value
`define CTRL_RL_LSB     0
`define CTRL_RL_MSB     5
`define CTRL_WL_LSB     8
`define CTRL_WL_MSB     13
`define CTRL_WDBI       16
`define CTRL_RDBI       17
`define CTRL_DM         18
`define CTRL_RST        32'h0000_080e

// ==========================================================
// cal fields and reset value
`define CAL_PAT_LSB     0
`define CAL_PAT_MSB     15
`define CAL_INV_LSB     16
`define CAL_INV_MSB     31
`define CAL_RST         32'h5555_3c5a

// ==========================================================
// status fields
`define STAT_WPTR_LSB   0
`define STAT_RPTR_LSB   4
`define STAT_WRIT_LSB   8
`define STAT_CKE        16

// ==========================================================
// command kinds on the decoded command port
`define CMD_DES         4'h0
`define CMD_MPC         4'h1
`define CMD_CAS2        4'h2
`define CMD_RD          4'h3
`define CMD_RDA         4'h4
`define CMD_WR          4'h5
`define CMD_MWR         4'h6
`define CMD_MRR         4'h7
`define CMD_MRW         4'h8
`define CMD_PDE         4'h9
`define CMD_SRPDE       4'ha

// ==========================================================
// training function codes in operand bits 5..0
`define MPC_RDFIFO      6'h01
`define MPC_RDCAL       6'h03
`define MPC_WRFIFO      6'h07

// ==========================================================
// token kinds, geometry and timing counts
`define TK_WR           2'h1
`define TK_RD           2'h2
`define TK_CAL          2'h3
`define FIFO_DEPTH      3'h5
`define LAST_ENTRY      3'h4
`define LAST_CLK        3'h7
`define LAT_DEPTH       32
`define MIN_RL          6'h03
`define MIN_WL          6'h01
`define UNDEF_FILL      18'h00000

`endif

// file: verilog/train_mem.v
// training fifo storage: 5 entries x 8 clocks x two 18-bit beats
`timescale 1ns/1ps
module train_mem (
	// clock
	input  wire        clk,
	input  wire        ce,
	// write port
	input  wire        we,
	input  wire [5:0]  waddr,
	input  wire [35:0] wdata,
	// read port, data one cycle later
	input  wire [5:0]  raddr,
	output reg  [35:0] rdata
);

	reg [35:0] cells [0:39];

	// ==========================================================
	// storage
	// no reset: unwritten words are masked by the caller
	always @(posedge clk) begin
		if (ce) begin
			if (we)
				cells[waddr] <= wdata;
			rdata <= cells[raddr];
		end
	end

endmodule

// file: verilog/lat_pipe.v
// latency shift line for launched fifo tokens with two taps
`timescale 1ns/1ps
module lat_pipe (
	// clock and reset
	input  wire       clk,
	input  wire       nrst,
	input  wire       ce,
	// token in, one per launch
	input  wire [5:0] tok_in,
	// taps
	input  wire [4:0] tap_a,
	input  wire [4:0] tap_b,
	output wire [5:0] tok_a,
	output wire [5:0] tok_b
);

	reg [6*32-1:0] stages;

	// ==========================================================
	// shift line; stage k holds a token k+1 cycles after launch
	always @(posedge clk) begin
		if (!nrst)
			stages <= {192{1'b0}};
		else if (ce)
			stages <= {stages[6*31-1:0], tok_in};
	end

	assign tok_a = stages[tap_a*6 +: 6];
	assign tok_b = stages[tap_b*6 +: 6];

endmodule

// file: verilog/dq_training_fifo.v
// dq write/read training fifo with read calibration pattern output
`timescale 1ns/1ps
`include "dq_train_regs.vh"
module dq_training_fifo (
	// clock, reset, clock enable
	input  wire        clk,
	input  wire        nrst,
	input  wire        ce,
	// decoded command port, same clock
	input  wire        cmd_valid,
	input  wire [3:0]  cmd_kind,
	input  wire [6:0]  cmd_op,
	// dram clock-enable pin, asynchronous to this logic
	input  wire        cke_pin,
	// data pins, two beats per clock, {dmi,dq} per beat, first beat low
	input  wire [35:0] dq_in,
	output reg  [35:0] dq_out,
	output reg         dq_oe,
	output reg         dmi_oe,
	// register port
	input  wire [7:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata
);

	// ==========================================================
	// functions
	function [2:0] ptr_inc;
		input [2:0] p;
		begin
			ptr_inc = (p == `LAST_ENTRY) ? 3'h0 : p + 3'h1;
		end
	endfunction

	function [4:0] tap_of;
		input [5:0] lat;
		input [5:0] lead;
		reg   [5:0] t;
		begin
			t = (lat < lead) ? 6'h00 : lat - lead;
			tap_of = (t > 6'h1f) ? 5'h1f : t[4:0];
		end
	endfunction

	// one clock of calibration pattern: beats 2c and 2c+1 per pin
	function [35:0] cal_beats;
		input [2:0]  c;
		input [15:0] pat;
		input [15:0] inv;
		reg   [3:0]  b0;
		reg   [3:0]  b1;
		begin
			b0 = {c, 1'b0};
			b1 = {c, 1'b1};
			cal_beats = {{2{pat[b1]}}, {16{pat[b1]}} ^ inv,
				{2{pat[b0]}}, {16{pat[b0]}} ^ inv};
		end
	endfunction

	// ==========================================================
	// registers
	reg  [31:0] ctrl;
	reg  [31:0] cal;
	reg  [2:0]  wr_ptr;
	reg  [2:0]  rd_ptr;
	reg  [4:0]  written;
	reg         mpc_pend;
	reg  [1:0]  mpc_kind;
	reg         cke_s1;
	reg         cke_s2;
	reg         cke_s3;
	reg         cke_lvl;
	reg         rd_act;
	reg  [2:0]  rd_cnt;
	reg  [2:0]  rd_entry;
	reg         rd_cal;
	reg         rd_ok;
	reg         q_act;
	reg  [2:0]  q_cnt;
	reg         q_cal;
	reg         q_ok;
	reg         wr_act;
	reg  [2:0]  wr_cnt;
	reg  [2:0]  wr_entry;
	reg  [5:0]  launch;

	wire [5:0]  rl;
	wire [5:0]  wl;
	wire [15:0] cal_pat;
	wire [15:0] cal_inv;
	wire [5:0]  tok_rd;
	wire [5:0]  tok_wr;
	wire [35:0] mem_q;
	wire        go;
	wire        is_cas;
	wire        is_arr_rd;
	wire        pd_entry;
	wire        disturb;
	wire        rd_tok_ok;
	wire        wr_tok_ok;

	assign rl      = ctrl[`CTRL_RL_MSB:`CTRL_RL_LSB];
	assign wl      = ctrl[`CTRL_WL_MSB:`CTRL_WL_LSB];
	assign cal_pat = cal[`CAL_PAT_MSB:`CAL_PAT_LSB];
	assign cal_inv = cal[`CAL_INV_MSB:`CAL_INV_LSB];

	// ==========================================================
	// clock-enable pin: three flops, change taken when last two agree
	always @(posedge clk) begin
		if (!nrst) begin
			cke_s1  <= 1'b1;
			cke_s2  <= 1'b1;
			cke_s3  <= 1'b1;
			cke_lvl <= 1'b1;
		end else if (ce) begin
			cke_s1 <= cke_pin;
			cke_s2 <= cke_s1;
			cke_s3 <= cke_s2;
			if (cke_s2 == cke_s3)
				cke_lvl <= cke_s3;
		end
	end

	// ==========================================================
	// command decode
	// bank and refresh state are not looked at: write-fifo is always
	// taken while clock enable is high
	assign go        = cmd_valid & cke_lvl;
	assign is_cas    = go & (cmd_kind == `CMD_CAS2);
	assign is_arr_rd = go & ((cmd_kind == `CMD_RD) |
		(cmd_kind == `CMD_RDA));
	assign pd_entry  = go & ((cmd_kind == `CMD_PDE) |
		(cmd_kind == `CMD_SRPDE));
	// commands that leave fifo contents undefined
	assign disturb   = ~cke_lvl | (go & ((cmd_kind == `CMD_WR) |
		(cmd_kind == `CMD_MWR) | (cmd_kind == `CMD_MRR) |
		(cmd_kind == `CMD_RD) | (cmd_kind == `CMD_RDA) |
		(is_cas & mpc_pend & (mpc_kind == `TK_CAL))));

	// multi-purpose command waits for the cas that follows it
	always @(posedge clk) begin
		if (!nrst) begin
			mpc_pend <= 1'b0;
			mpc_kind <= 2'h0;
		end else if (ce && go) begin
			mpc_pend <= 1'b0;
			// bit 6 low is a no-op; unknown codes are reserved
			if (cmd_kind == `CMD_MPC && cmd_op[6]) begin
				case (cmd_op[5:0])
				`MPC_WRFIFO: begin
					mpc_pend <= 1'b1;
					mpc_kind <= `TK_WR;
				end
				`MPC_RDFIFO: begin
					mpc_pend <= 1'b1;
					mpc_kind <= `TK_RD;
				end
				`MPC_RDCAL: begin
					mpc_pend <= 1'b1;
					mpc_kind <= `TK_CAL;
				end
				default: begin
					mpc_pend <= 1'b0;
				end
				endcase
			end
		end
	end

	// ==========================================================
	// pointers and written-entry mask
	// cas operands are ignored here, relying on them being low
	always @* begin
		launch = 6'h00;
		if (is_cas && mpc_pend) begin
			case (mpc_kind)
			`TK_WR:  launch = {1'b1, `TK_WR, wr_ptr};
			`TK_RD:  launch = {1'b1, `TK_RD, rd_ptr};
			`TK_CAL: launch = {1'b1, `TK_CAL, 3'h0};
			default: launch = 6'h00;
			endcase
		end
	end

	always @(posedge clk) begin
		if (!nrst) begin
			wr_ptr  <= 3'h0;
			rd_ptr  <= 3'h0;
			written <= 5'h00;
		end else if (ce) begin
			if (pd_entry)
				wr_ptr <= 3'h0;
			else if (is_arr_rd)
				wr_ptr <= ptr_inc(wr_ptr);
			else if (launch[5] && launch[4:3] == `TK_WR)
				wr_ptr <= ptr_inc(wr_ptr);
			if (is_arr_rd)
				rd_ptr <= ptr_inc(rd_ptr);
			else if (launch[5] && launch[4:3] == `TK_RD)
				rd_ptr <= ptr_inc(rd_ptr);
			// a new write-fifo marks its entry; disturbance wipes the rest
			if (launch[5] && launch[4:3] == `TK_WR)
				written <= (disturb ? 5'h00 : written) |
					(5'h01 << wr_ptr);
			else if (disturb)
				written <= 5'h00;
		end
	end

	// ==========================================================
	// latency line: read taps three early for engine and memory stages
	lat_pipe u_lat (
		.clk    (clk),
		.nrst   (nrst),
		.ce     (ce),
		.tok_in (launch),
		.tap_a  (tap_of(rl, `MIN_RL)),
		.tap_b  (tap_of(wl, `MIN_WL)),
		.tok_a  (tok_rd),
		.tok_b  (tok_wr)
	);

	assign rd_tok_ok = tok_rd[5] & (tok_rd[4:3] != `TK_WR);
	assign wr_tok_ok = tok_wr[5] & (tok_wr[4:3] == `TK_WR);

	// ==========================================================
	// write engine: eight clocks of two beats into the addressed entry
	always @(posedge clk) begin
		if (!nrst) begin
			wr_act   <= 1'b0;
			wr_cnt   <= 3'h0;
			wr_entry <= 3'h0;
		end else if (ce) begin
			if (wr_tok_ok && (!wr_act || wr_cnt == `LAST_CLK)) begin
				wr_act   <= 1'b1;
				wr_cnt   <= 3'h0;
				wr_entry <= tok_wr[2:0];
			end else if (wr_act) begin
				wr_act <= (wr_cnt != `LAST_CLK);
				wr_cnt <= wr_cnt + 3'h1;
			end
		end
	end

	// ==========================================================
	// read engine; back-to-back tokens chain with no gap
	always @(posedge clk) begin
		if (!nrst) begin
			rd_act   <= 1'b0;
			rd_cnt   <= 3'h0;
			rd_entry <= 3'h0;
			rd_cal   <= 1'b0;
			rd_ok    <= 1'b0;
		end else if (ce) begin
			if (rd_tok_ok && (!rd_act || rd_cnt == `LAST_CLK)) begin
				rd_act   <= 1'b1;
				rd_cnt   <= 3'h0;
				rd_entry <= tok_rd[2:0];
				rd_cal   <= (tok_rd[4:3] == `TK_CAL);
				rd_ok    <= written[tok_rd[2:0]];
			end else if (rd_act) begin
				rd_act <= (rd_cnt != `LAST_CLK);
				rd_cnt <= rd_cnt + 3'h1;
			end
		end
	end

	// five bursts of sixteen beats, each clock a beat pair
	// reads only fetch, so contents never change by reading
	train_mem u_mem (
		.clk   (clk),
		.ce    (ce),
		.we    (wr_act),
		.waddr ({wr_entry, wr_cnt}),
		.wdata (dq_in),
		.raddr ({rd_entry, rd_cnt}),
		.rdata (mem_q)
	);

	// ==========================================================
	// output stage, one cycle behind memory read
	always @(posedge clk) begin
		if (!nrst) begin
			q_act  <= 1'b0;
			q_cnt  <= 3'h0;
			q_cal  <= 1'b0;
			q_ok   <= 1'b0;
			dq_out <= 36'h000000000;
			dq_oe  <= 1'b0;
			dmi_oe <= 1'b0;
		end else if (ce) begin
			q_act <= rd_act;
			q_cnt <= rd_cnt;
			q_cal <= rd_cal;
			q_ok  <= rd_ok;
			dq_oe <= q_act;
			// mask pins only when a dmi function is on
			dmi_oe <= q_act & (ctrl[`CTRL_WDBI] | ctrl[`CTRL_RDBI] |
				ctrl[`CTRL_DM]);
			if (!q_act)
				dq_out <= 36'h000000000;
			else if (q_cal)
				dq_out <= cal_beats(q_cnt, cal_pat, cal_inv);
			else if (q_ok)
				dq_out <= mem_q;
			else
				dq_out <= {`UNDEF_FILL, `UNDEF_FILL};
		end
	end

	// ==========================================================
	// register port: rl/wl below the minimum are clamped, not refused
	always @(posedge clk) begin
		if (!nrst) begin
			ctrl      <= `CTRL_RST;
			cal       <= `CAL_RST;
			reg_rdata <= 32'h00000000;
		end else if (ce) begin
			if (reg_wr) begin
				case (reg_addr)
				`REG_CTRL: ctrl <= reg_wdata & 32'h0007_3f3f;
				`REG_CAL:  cal  <= reg_wdata;
				default:   ctrl <= ctrl;
				endcase
			end
			reg_rdata <= 32'h00000000;
			if (reg_rd) begin
				case (reg_addr)
				`REG_CTRL: reg_rdata <= ctrl;
				`REG_CAL:  reg_rdata <= cal;
				`REG_STAT: reg_rdata <= {15'h0000, cke_lvl,
					3'h0, written, 1'b0, rd_ptr, 1'b0, wr_ptr};
				default:   reg_rdata <= 32'h00000000;
				endcase
			end
		end
	end

endmodule

// file: testbench/train_ctrl.sv
// controller model: training command pairs and write bursts
`timescale 1ns/1ps
`include "dq_train_regs.vh"
module train_ctrl (
	// clock
	input  wire        clk,
	// request from the bench
	input  wire        go,
	input  wire [3:0]  kind,
	input  wire [6:0]  op,
	input  wire [17:0] seed,
	output wire        busy,
	// pins toward the fifo
	output reg         cmd_valid = 1'b0,
	output reg  [3:0]  cmd_kind = 4'h0,
	output reg  [6:0]  cmd_op = 7'h00,
	output reg  [35:0] dq_in = 36'h0
);
	// =====
	// sequencer
	reg  [5:0]  cnt = 6'h3f;
	reg  [5:0]  last = 6'h00;
	reg  [17:0] sd = 18'h0;
	reg         two = 1'b0;
	reg         wr = 1'b0;
	wire [5:0]  b = cnt - 6'h09;
	wire [5:0]  c = op[5:0];
	wire        train = kind == `CMD_MPC && op[6] && (c == `MPC_RDFIFO
		|| c == `MPC_RDCAL || c == `MPC_WRFIFO);
	assign busy = cnt < last;
	always @(posedge clk) begin
		cnt <= (cnt == 6'h3f) ? cnt : cnt + 6'h01;
		cmd_valid <= two && cnt == 6'h00;
		cmd_kind <= `CMD_CAS2;
		cmd_op <= 7'h00;
		// idle data lines copy the cycle counter, which holds at 6'h3f once saturated, so stale beats never match
		dq_in <= {6{cnt}};
		// write latency fixed at the reset value of 8
		if (wr && cnt >= 6'h09 && cnt <= 6'h10)
			dq_in <= {sd + {11'h0, b, 1'b1}, sd + {11'h0, b, 1'b0}};
		if (go) begin
			cnt <= 6'h00;
			cmd_valid <= 1'b1;
			cmd_kind <= kind;
			cmd_op <= op;
			two <= train;
			wr <= train && c == `MPC_WRFIFO;
			last <= !train ? 6'h01 : (c == `MPC_WRFIFO ? 6'h10 : 6'h06);
			sd <= seed;
		end
	end
endmodule

// file: testbench/dq_fifo_checker.sv
// assertion checker for the dq training fifo ports
`timescale 1ns/1ps
`include "dq_train_regs.vh"
module dq_fifo_checker (
	// clock and reset
	input wire        clk,
	input wire        nrst,
	// command port
	input wire        cmd_valid,
	input wire [3:0]  cmd_kind,
	input wire [6:0]  cmd_op,
	// data pins
	input wire [35:0] dq_out,
	input wire        dq_oe,
	input wire        dmi_oe,
	// register port
	input wire [7:0]  reg_addr,
	input wire [31:0] reg_wdata,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [31:0] reg_rdata
);
	// =====
	// shadow pointers and launch history
	reg        armed;
	reg [5:0]  code;
	reg [47:0] sr;
	reg [5:0]  rl;
	reg [2:0]  en;
	reg [2:0]  wp;
	reg [2:0]  rp;
	wire       cas = cmd_valid && cmd_kind == `CMD_CAS2 && armed;
	wire       ard = cmd_valid && (cmd_kind == `CMD_RD
		|| cmd_kind == `CMD_RDA);
	wire [5:0] c = cmd_op[5:0];
	wire       ok = c == `MPC_RDFIFO || c == `MPC_RDCAL || c == `MPC_WRFIFO;
	wire [47:0] sh = sr >> rl;
	wire       exp_oe = |sh[7:0];
	always @(posedge clk) begin
		if (!nrst) begin
			armed <= 1'b0;
			code <= 6'h00;
			sr <= 48'h0;
			rl <= 6'h0e;
			en <= 3'h0;
			wp <= 3'h0;
			rp <= 3'h0;
		end else begin
			if (cmd_valid)
				armed <= cmd_kind == `CMD_MPC && cmd_op[6] && ok;
			if (cmd_valid)
				code <= c;
			sr <= {sr[46:0], cas && code != `MPC_WRFIFO};
			if ((cas && code == `MPC_WRFIFO) || ard)
				wp <= (wp == `LAST_ENTRY) ? 3'h0 : wp + 3'h1;
			if ((cas && code == `MPC_RDFIFO) || ard)
				rp <= (rp == `LAST_ENTRY) ? 3'h0 : rp + 3'h1;
			if (cmd_valid && (cmd_kind == `CMD_PDE
				|| cmd_kind == `CMD_SRPDE))
				wp <= 3'h0;
			if (reg_wr && reg_addr == `REG_CTRL) begin
				rl <= reg_wdata[5:0] < `MIN_RL ? `MIN_RL : reg_wdata[5:0];
				en <= reg_wdata[18:16];
			end
		end
	end
	// =====
	// properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence stat_rd;
		reg_rd && reg_addr == `REG_STAT;
	endsequence
	oe_timing_a: assert property (dq_oe == exp_oe)
		else $error("data enable off its read latency slot");
	burst_len_a: assert property ($rose(dq_oe) |-> dq_oe[*8])
		else $error("burst shorter than eight clocks");
	idle_zero_a: assert property (!dq_oe |-> dq_out == 36'h0)
		else $error("data bus not zero while idle");
	dmi_follow_a: assert property (dmi_oe == (dq_oe && en != 3'h0))
		else $error("mask pin enable wrong");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside its slot");
	unmapped_zero_a: assert property (reg_rd && reg_addr != `REG_CTRL
		&& reg_addr != `REG_CAL && reg_addr != `REG_STAT
		|=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	wptr_stat_a: assert property (stat_rd |=> reg_rdata[2:0] == $past(wp))
		else $error("write pointer wrong");
	rptr_stat_a: assert property (stat_rd |=> reg_rdata[6:4] == $past(rp))
		else $error("read pointer wrong");
endmodule
bind dq_training_fifo dq_fifo_checker i_dq_fifo_checker (.clk, .nrst,
	.cmd_valid, .cmd_kind, .cmd_op, .dq_out, .dq_oe, .dmi_oe, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

// file: testbench/test_dq_training_fifo.sv
// self-checking bench for the dq training fifo
`timescale 1ns/1ps
`include "dq_train_regs.vh"
module test_dq_training_fifo;
	// =====
	// stimulus and wiring
	reg          clk = 1'b0;
	reg          nrst = 1'b0;
	reg          go = 1'b0;
	reg  [3:0]   kind = 4'h0;
	reg  [6:0]   op = 7'h00;
	reg  [17:0]  seed = 18'h0;
	reg  [7:0]   reg_addr = 8'h00;
	reg  [31:0]  reg_wdata = 32'h0;
	reg          reg_wr = 1'b0;
	reg          reg_rd = 1'b0;
	reg          cke_pin = 1'b1;
	wire         busy, cmd_valid, dq_oe, dmi_oe;
	wire [3:0]   cmd_kind;
	wire [6:0]   cmd_op;
	wire [35:0]  dq_in, dq_out;
	wire [31:0]  reg_rdata;
	int          bad_count = 0;
	int          cmp_count = 0;
	logic [35:0] got_q[$];
	logic [35:0] exp_q[$];
	localparam [31:0] CAL = `CAL_RST;
	// rows: {op, seed written or seed expected back}; seed 0 = unwritten
	logic [24:0] rows [0:10] = '{{7'h47, 18'h00a11}, {7'h47, 18'h00b22},
		{7'h47, 18'h00c33}, {7'h41, 18'h00a11}, {7'h41, 18'h00b22},
		{7'h41, 18'h00c33}, {7'h41, 18'h0}, {7'h41, 18'h0},
		{7'h41, 18'h00a11}, {7'h41, 18'h00b22}, {7'h41, 18'h00c33}};
	initial begin
		forever #12.5 clk = ~clk;
	end
	train_ctrl i_train_ctrl (.clk(clk), .go(go), .kind(kind), .op(op),
		.seed(seed), .busy(busy), .cmd_valid(cmd_valid),
		.cmd_kind(cmd_kind), .cmd_op(cmd_op), .dq_in(dq_in));
	dq_training_fifo i_dq_training_fifo (.clk(clk), .nrst(nrst),
		.ce(1'b1), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
		.cmd_op(cmd_op), .cke_pin(cke_pin), .dq_in(dq_in), .dq_out(dq_out),
		.dq_oe(dq_oe), .dmi_oe(dmi_oe), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));
	always @(posedge clk)
		if (dq_oe === 1'b1)
			got_q.push_back(dq_out);
	// =====
	// helpers
	function [17:0] sk(input int k);
		sk = {6'h00, k[3:0], 8'h5a};
	endfunction
	function [17:0] calb(input [3:0] b);
		calb = {{2{CAL[b]}}, {16{CAL[b]}} ^ CAL[31:16]};
	endfunction
	task check(input [35:0] got, input [35:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task tally_and_finish;
		if (bad_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task send(input [3:0] k, input [6:0] o, input [17:0] s);
		int n;
		kind <= k;
		op <= o;
		seed <= s;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (busy && n < 40);
		check({35'h0, busy}, 36'h0);
		@(posedge clk);
	endtask
	task expect_rd(input [17:0] s);
		for (int j = 0; j < 8; j++)
			exp_q.push_back(s == 18'h0 ? 36'h0 : {s + 18'(2 * j + 1), s + 18'(2 * j)});
	endtask
	task drain;
		int n;
		n = 0;
		while (got_q.size() < exp_q.size() && n < 300) begin
			@(posedge clk);
			n++;
		end
		check(36'(got_q.size()), 36'(exp_q.size()));
		while (got_q.size() > 0 && exp_q.size() > 0)
			check(got_q.pop_front(), exp_q.pop_front());
		got_q.delete();
		exp_q.delete();
	endtask
	task reg_write(input [7:0] a, input [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task reg_check(input [7:0] a, input [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		check({4'h0, reg_rdata}, {4'h0, e});
		@(posedge clk);
	endtask
	// =====
	// main sequence
	initial begin
		int i;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		reg_check(`REG_CTRL, `CTRL_RST);
		reg_check(`REG_CAL, `CAL_RST);
		reg_check(8'h0c, 32'h0);
		reg_check(`REG_STAT, 32'h0001_0000);
		reg_write(`REG_CTRL, 32'hffff_c8ce);
		reg_check(`REG_CTRL, 32'h0007_080e);
		// no array reads here, reads = writes + 5 at the end
		for (i = 0; i < 11; i++) begin
			send(`CMD_MPC, rows[i][24:18], rows[i][17:0]);
			if (rows[i][24:18] == 7'h41)
				expect_rd(rows[i][17:0]);
		end
		drain;
		reg_write(`REG_CTRL, `CTRL_RST);
		send(`CMD_PDE, 7'h00, 18'h0);
		reg_check(`REG_STAT, 32'h0001_0730);
		reg_write(`REG_STAT, 32'hffff_ffff);
		repeat (12) @(posedge clk);
		for (i = 0; i < 6; i++)
			send(`CMD_MPC, 7'h47, sk(i));
		for (i = 0; i < 6; i++) begin
			send(`CMD_MPC, 7'h41, 18'h0);
			expect_rd(sk((3 + i) % 5 == 0 ? 5 : (3 + i) % 5));
		end
		drain;
		// clock enable low wipes the written mask once the sync settles
		cke_pin <= 1'b0;
		repeat (6) @(posedge clk);
		reg_check(`REG_STAT, 32'h0000_0041);
		cke_pin <= 1'b1;
		repeat (6) @(posedge clk);
		send(`CMD_RD, 7'h00, 18'h0);
		reg_check(`REG_STAT, 32'h0001_0002);
		send(`CMD_MPC, 7'h07, 18'h0);
		send(`CMD_CAS2, 7'h00, 18'h0);
		reg_check(`REG_STAT, 32'h0001_0002);
		// reserved code with bit 6 high must launch nothing either
		send(`CMD_MPC, 7'h7f, 18'h0);
		send(`CMD_CAS2, 7'h00, 18'h0);
		reg_check(`REG_STAT, 32'h0001_0002);
		repeat (12) @(posedge clk);
		send(`CMD_MPC, 7'h43, 18'h0);
		for (i = 0; i < 8; i++)
			exp_q.push_back({calb(4'(2 * i + 1)), calb(4'(2 * i))});
		send(`CMD_SRPDE, 7'h00, 18'h0);
		reg_check(`REG_STAT, 32'h0001_0000);
		drain;
		tally_and_finish;
	end
endmodule
